//--- pkg/ldd_pkg.sv
package ldd_pkg;

  localparam int CH_W         = 16;   // sink channels per device
  localparam int CLK_NS       = 100;  // clk_sys period
  localparam int STEP_NS      = 20;   // turn-on stagger per channel
  localparam int DIAG_NS      = 2000; // least gate time in reduced-current test
  // longest step rounds down, least time rounds up, neither below one cycle
  localparam int STEP_CYC     = (STEP_NS / CLK_NS) > 0 ? (STEP_NS / CLK_NS) : 1;
  localparam int DIAG_CYC     = ((DIAG_NS + CLK_NS - 1) / CLK_NS) > 0 ?
                                ((DIAG_NS + CLK_NS - 1) / CLK_NS) : 1;
  localparam int SCK_HALF_DEF = 4;    // host serial clock half period in cycles

  // clock pulses given while the load strobe is high
  localparam logic [1:0] SEL_TEMP  = 2'h0;
  localparam logic [1:0] SEL_OPEN  = 2'h1;
  localparam logic [1:0] SEL_SHORT = 2'h2;
  localparam logic [1:0] SEL_DIAG  = 2'h3;

  localparam logic [15:0] ALL_ON    = 16'hffff;
  localparam logic [15:0] SHIFT_RST = 16'hffff;
  localparam logic [15:0] DISP_RST  = 16'h0000;
  localparam logic [7:0]  STG_MAX   = 8'hff;

  typedef enum logic [1:0] {
    DS_NORMAL,
    DS_ARMED,
    DS_TEST,
    DS_DONE
  } ldd_dstate_t;

  typedef enum logic [1:0] {
    OP_FRAME,
    OP_SELECT,
    OP_DIAG
  } ldd_op_t;

  typedef enum logic [3:0] {
    H_IDLE,
    H_SHIFT_LO,
    H_SHIFT_HI,
    H_LD_RISE,
    H_PULSE_HI,
    H_PULSE_LO,
    H_LD_FALL,
    H_TEST,
    H_DONE
  } ldd_hstate_t;

endpackage

//--- pkg/ldd_link_if.sv
`timescale 1ns/1ps
interface ldd_link_if;
  logic serial_clk;
  logic chain_serial_in;
  logic chain_serial_out;
  logic load_strobe;
  logic drive_gate_n;

  modport dev (
    input  serial_clk,
    input  chain_serial_in,
    input  load_strobe,
    input  drive_gate_n,
    output chain_serial_out
  );

  modport host (
    output serial_clk,
    output chain_serial_in,
    output load_strobe,
    output drive_gate_n,
    input  chain_serial_out
  );
endinterface

//--- hdl/ldd_dev_end.sv
`timescale 1ns/1ps
module ldd_dev_end #(
  parameter int CH = ldd_pkg::CH_W
) (
  input  wire logic          clk_sys,              // system clock
  input  wire logic          resetn,               // async reset
  input  wire logic          ce,                   // clock enable
  input  wire logic [CH-1:0] led_open_n,           // open-load sense, 0 = open
  input  wire logic [CH-1:0] led_short_n,          // short sense, 0 = short
  input  wire logic          temp_ok,              // 0 = overheated
  output logic      [CH-1:0] sink_outputs,         // 1 = channel sinks
  output logic               reduced_test_current, // low-current test active
  ldd_link_if.dev            link                  // serial chain pins
);

  ////////////////////////////////////////////////////////////////////////////
  // pin edge detection

  logic sclk_q_r;
  logic ld_q_r;
  logic gate_n_q_r;
  logic sclk_rise;
  logic ld_rise;
  logic ld_fall;
  logic gate_fall;
  logic gate_rise;

  always_comb
  begin
    sclk_rise = link.serial_clk & ~sclk_q_r;
    ld_rise   = link.load_strobe & ~ld_q_r;
    ld_fall   = ~link.load_strobe & ld_q_r;
    gate_fall = ~link.drive_gate_n & gate_n_q_r;
    gate_rise = link.drive_gate_n & ~gate_n_q_r;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_q_r   <= 1'b0;
      ld_q_r     <= 1'b0;
      gate_n_q_r <= 1'b1;
    end
    else if (ce)
    begin
      sclk_q_r   <= link.serial_clk;
      ld_q_r     <= link.load_strobe;
      gate_n_q_r <= link.drive_gate_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift path, latches, diagnosis sequence

  ldd_pkg::ldd_dstate_t st_r;
  ldd_pkg::ldd_dstate_t st_nxt;
  logic [CH-1:0] shift_r;
  logic [CH-1:0] shift_nxt;
  logic [CH-1:0] disp_r;
  logic [CH-1:0] disp_nxt;
  logic [CH-1:0] saved_r;
  logic [CH-1:0] saved_nxt;
  logic [CH-1:0] open_rep_r;
  logic [CH-1:0] open_rep_nxt;
  logic [CH-1:0] short_rep_r;
  logic [CH-1:0] short_rep_nxt;
  logic          temp_r;
  logic          temp_nxt;
  logic [1:0]    pulses_r;
  logic [1:0]    pulses_nxt;
  logic          fresh_r;
  logic          fresh_nxt;
  logic          sdo_r;
  logic          sdo_nxt;
  logic          low_cur_r;
  logic          low_cur_nxt;
  logic [CH-1:0] pattern;

  // pattern that the sinks show; the test itself lights every channel
  always_comb
  begin
    if (st_r == ldd_pkg::DS_TEST)
      pattern = ldd_pkg::ALL_ON[CH-1:0];
    else
      pattern = disp_r;
  end

  always_comb
  begin
    st_nxt        = st_r;
    shift_nxt     = shift_r;
    disp_nxt      = disp_r;
    saved_nxt     = saved_r;
    open_rep_nxt  = open_rep_r;
    short_rep_nxt = short_rep_r;
    temp_nxt      = temp_r;
    pulses_nxt    = pulses_r;
    fresh_nxt     = fresh_r;
    low_cur_nxt   = low_cur_r;

    if (sclk_rise)
    begin
      shift_nxt = {link.chain_serial_in, shift_r[CH-1:1]};
      fresh_nxt = fresh_r | ~link.load_strobe;
      if (link.load_strobe && pulses_r != ldd_pkg::SEL_DIAG)
        pulses_nxt = pulses_r + 2'h1;
    end

    if (ld_rise)
    begin
      pulses_nxt = 2'h0;
      fresh_nxt  = 1'b0;
      // only a newly shifted frame reaches the display; a strobe that just
      // selects a report or a test keeps the pattern being shown
      if (st_r == ldd_pkg::DS_NORMAL && fresh_r)
        disp_nxt = shift_r;
    end

    if (gate_rise)
    begin
      temp_nxt      = temp_ok;
      // channels that were dark cannot be judged and read as one
      open_rep_nxt  = led_open_n | ~pattern;
      short_rep_nxt = led_short_n | ~pattern;
      if (st_r == ldd_pkg::DS_TEST)
      begin
        st_nxt      = ldd_pkg::DS_DONE;
        low_cur_nxt = 1'b0;
      end
    end

    if (ld_fall)
    begin
      unique case (pulses_r)
        ldd_pkg::SEL_OPEN:  shift_nxt = open_rep_r;
        ldd_pkg::SEL_SHORT: shift_nxt = short_rep_r;
        ldd_pkg::SEL_DIAG:  shift_nxt = shift_r;
        ldd_pkg::SEL_TEMP:  shift_nxt = {{(CH-1){1'b1}}, temp_r};
      endcase
      if (pulses_r == ldd_pkg::SEL_DIAG && st_r == ldd_pkg::DS_NORMAL)
      begin
        st_nxt    = ldd_pkg::DS_ARMED;
        saved_nxt = disp_r;
      end
      else if (st_r == ldd_pkg::DS_DONE)
      begin
        st_nxt   = ldd_pkg::DS_NORMAL;
        disp_nxt = saved_r;
      end
    end

    // the strobe fall that arms the test and the gate fall may share a cycle
    if (gate_fall && st_nxt == ldd_pkg::DS_ARMED)
    begin
      st_nxt      = ldd_pkg::DS_TEST;
      low_cur_nxt = 1'b1;
    end

    sdo_nxt = shift_nxt[0];
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r        <= ldd_pkg::DS_NORMAL;
      shift_r     <= ldd_pkg::SHIFT_RST[CH-1:0];
      disp_r      <= ldd_pkg::DISP_RST[CH-1:0];
      saved_r     <= ldd_pkg::DISP_RST[CH-1:0];
      open_rep_r  <= ldd_pkg::ALL_ON[CH-1:0];
      short_rep_r <= ldd_pkg::ALL_ON[CH-1:0];
      temp_r      <= 1'b1;
      pulses_r    <= 2'h0;
      fresh_r     <= 1'b0;
      sdo_r       <= 1'b1;
      low_cur_r   <= 1'b0;
    end
    else if (ce)
    begin
      st_r        <= st_nxt;
      shift_r     <= shift_nxt;
      disp_r      <= disp_nxt;
      saved_r     <= saved_nxt;
      open_rep_r  <= open_rep_nxt;
      short_rep_r <= short_rep_nxt;
      temp_r      <= temp_nxt;
      pulses_r    <= pulses_nxt;
      fresh_r     <= fresh_nxt;
      sdo_r       <= sdo_nxt;
      low_cur_r   <= low_cur_nxt;
    end
  end

  assign link.chain_serial_out = sdo_r;
  assign reduced_test_current  = low_cur_r;

  ////////////////////////////////////////////////////////////////////////////
  // staggered turn-on limits inrush when the gate opens

  function automatic logic [7:0] on_delay(input int idx);
    on_delay = 8'(idx * ldd_pkg::STEP_CYC);
  endfunction

  logic [7:0]    stg_r;
  logic [7:0]    stg_nxt;
  logic [CH-1:0] sink_r;
  logic [CH-1:0] sink_nxt;

  always_comb
  begin
    if (link.drive_gate_n)
      stg_nxt = 8'h00;
    else if (stg_r != ldd_pkg::STG_MAX)
      stg_nxt = stg_r + 8'h01;
    else
      stg_nxt = stg_r;
    for (int i = 0; i < CH; i++)
      sink_nxt[i] = pattern[i] & ~link.drive_gate_n & (stg_r >= on_delay(i));
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      stg_r  <= 8'h00;
      sink_r <= '0;
    end
    else if (ce)
    begin
      stg_r  <= stg_nxt;
      sink_r <= sink_nxt;
    end
  end

  assign sink_outputs = sink_r;

endmodule

//--- hdl/ldd_host_end.sv
`timescale 1ns/1ps
module ldd_host_end #(
  parameter int N_DEV    = 1,
  parameter int SCK_HALF = ldd_pkg::SCK_HALF_DEF,
  parameter int NB       = N_DEV * ldd_pkg::CH_W
) (
  input  wire logic          clk_sys,   // system clock
  input  wire logic          resetn,    // async reset
  input  wire logic          ce,        // clock enable
  input  wire logic          cmd_valid, // start a command
  input  wire logic [1:0]    cmd_op,    // ldd_op_t code
  input  wire logic [1:0]    cmd_sel,   // report select pulses
  input  wire logic [NB-1:0] tx_data,   // frame data, bit 0 first
  output logic               cmd_ready, // idle, command accepted
  output logic      [NB-1:0] rx_data,   // bits returned by the chain
  output logic               done,      // command finished
  ldd_link_if.host           link       // serial chain pins
);

  ldd_pkg::ldd_hstate_t st_r;
  ldd_pkg::ldd_hstate_t st_nxt;
  logic [15:0]   tmr_r;
  logic [15:0]   tmr_nxt;
  logic [15:0]   bit_r;
  logic [15:0]   bit_nxt;
  logic [NB-1:0] tx_r;
  logic [NB-1:0] tx_nxt;
  logic [NB-1:0] rx_r;
  logic [NB-1:0] rx_nxt;
  logic [1:0]    sel_r;
  logic [1:0]    sel_nxt;
  logic [1:0]    pulses_r;
  logic [1:0]    pulses_nxt;
  logic          diag_r;
  logic          diag_nxt;
  logic          sclk_r;
  logic          sclk_nxt;
  logic          sdi_r;
  logic          sdi_nxt;
  logic          ld_r;
  logic          ld_nxt;
  logic          gate_n_r;
  logic          gate_n_nxt;
  logic          ready_r;
  logic          ready_nxt;
  logic          done_r;
  logic          done_nxt;
  logic          half_up;
  logic          test_up;

  always_comb
  begin
    half_up    = (tmr_r == 16'(SCK_HALF - 1));
    test_up    = (tmr_r == 16'(ldd_pkg::DIAG_CYC - 1));
    st_nxt     = st_r;
    tmr_nxt    = tmr_r + 16'h0001;
    bit_nxt    = bit_r;
    tx_nxt     = tx_r;
    rx_nxt     = rx_r;
    sel_nxt    = sel_r;
    pulses_nxt = pulses_r;
    diag_nxt   = diag_r;
    sclk_nxt   = sclk_r;
    sdi_nxt    = sdi_r;
    ld_nxt     = ld_r;
    gate_n_nxt = gate_n_r;
    ready_nxt  = ready_r;
    done_nxt   = 1'b0;

    unique case (st_r)
      ldd_pkg::H_IDLE:
      begin
        tmr_nxt = 16'h0000;
        if (cmd_valid)
        begin
          ready_nxt = 1'b0;
          sel_nxt   = cmd_sel;
          if (cmd_op == ldd_pkg::OP_FRAME)
          begin
            tx_nxt  = tx_data;
            sdi_nxt = tx_data[0];
            bit_nxt = 16'h0000;
            st_nxt  = ldd_pkg::H_SHIFT_LO;
          end
          else
          begin
            // gate rise first so fresh results are captured
            gate_n_nxt = 1'b1;
            diag_nxt   = (cmd_op == ldd_pkg::OP_DIAG);
            pulses_nxt = (cmd_op == ldd_pkg::OP_DIAG) ? ldd_pkg::SEL_DIAG : cmd_sel;
            st_nxt     = ldd_pkg::H_LD_RISE;
          end
        end
      end
      ldd_pkg::H_SHIFT_LO:
        if (half_up)
        begin
          tmr_nxt  = 16'h0000;
          rx_nxt   = {link.chain_serial_out, rx_r[NB-1:1]};
          sclk_nxt = 1'b1;
          st_nxt   = ldd_pkg::H_SHIFT_HI;
        end
      ldd_pkg::H_SHIFT_HI:
        if (half_up)
        begin
          tmr_nxt  = 16'h0000;
          sclk_nxt = 1'b0;
          tx_nxt   = {1'b1, tx_r[NB-1:1]};
          sdi_nxt  = tx_r[1 % NB];
          bit_nxt  = bit_r + 16'h0001;
          if (bit_r == 16'(NB - 1))
          begin
            pulses_nxt = 2'h0;
            st_nxt     = ldd_pkg::H_LD_RISE;
          end
          else
            st_nxt = ldd_pkg::H_SHIFT_LO;
        end
      ldd_pkg::H_LD_RISE:
        if (half_up)
        begin
          tmr_nxt = 16'h0000;
          ld_nxt  = 1'b1;
          st_nxt  = (pulses_r != 2'h0) ? ldd_pkg::H_PULSE_HI : ldd_pkg::H_LD_FALL;
        end
      ldd_pkg::H_PULSE_HI:
        if (half_up)
        begin
          tmr_nxt  = 16'h0000;
          sclk_nxt = 1'b1;
          st_nxt   = ldd_pkg::H_PULSE_LO;
        end
      ldd_pkg::H_PULSE_LO:
        if (half_up)
        begin
          tmr_nxt    = 16'h0000;
          sclk_nxt   = 1'b0;
          pulses_nxt = pulses_r - 2'h1;
          st_nxt     = (pulses_r == 2'h1) ? ldd_pkg::H_LD_FALL : ldd_pkg::H_PULSE_HI;
        end
      ldd_pkg::H_LD_FALL:
        if (half_up)
        begin
          tmr_nxt    = 16'h0000;
          ld_nxt     = 1'b0;
          gate_n_nxt = 1'b0;
          st_nxt     = diag_r ? ldd_pkg::H_TEST : ldd_pkg::H_DONE;
        end
      ldd_pkg::H_TEST:
        if (test_up)
        begin
          tmr_nxt    = 16'h0000;
          gate_n_nxt = 1'b1;
          diag_nxt   = 1'b0;
          pulses_nxt = sel_r;
          st_nxt     = ldd_pkg::H_LD_RISE;
        end
      ldd_pkg::H_DONE:
      begin
        tmr_nxt   = 16'h0000;
        done_nxt  = 1'b1;
        ready_nxt = 1'b1;
        st_nxt    = ldd_pkg::H_IDLE;
      end
      default:
        st_nxt = ldd_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r     <= ldd_pkg::H_IDLE;
      tmr_r    <= 16'h0000;
      bit_r    <= 16'h0000;
      tx_r     <= '1;
      rx_r     <= '0;
      sel_r    <= 2'h0;
      pulses_r <= 2'h0;
      diag_r   <= 1'b0;
      sclk_r   <= 1'b0;
      sdi_r    <= 1'b1;
      ld_r     <= 1'b0;
      gate_n_r <= 1'b1;
      ready_r  <= 1'b1;
      done_r   <= 1'b0;
    end
    else if (ce)
    begin
      st_r     <= st_nxt;
      tmr_r    <= tmr_nxt;
      bit_r    <= bit_nxt;
      tx_r     <= tx_nxt;
      rx_r     <= rx_nxt;
      sel_r    <= sel_nxt;
      pulses_r <= pulses_nxt;
      diag_r   <= diag_nxt;
      sclk_r   <= sclk_nxt;
      sdi_r    <= sdi_nxt;
      ld_r     <= ld_nxt;
      gate_n_r <= gate_n_nxt;
      ready_r  <= ready_nxt;
      done_r   <= done_nxt;
    end
  end

  assign link.serial_clk      = sclk_r;
  assign link.chain_serial_in = sdi_r;
  assign link.load_strobe     = ld_r;
  assign link.drive_gate_n    = gate_n_r;
  assign cmd_ready            = ready_r;
  assign rx_data              = rx_r;
  assign done                 = done_r;

endmodule

//--- sim/ldd_link_props.sv
`timescale 1ns/1ps
module ldd_link_props #(
  parameter int NB = 16
) (
  input wire logic clk_sys,          // system clock
  input wire logic resetn,           // async reset
  input wire logic serial_clk,       // chain clock
  input wire logic chain_serial_in,  // data into device
  input wire logic chain_serial_out, // data out of device
  input wire logic load_strobe,      // load strobe
  input wire logic drive_gate_n      // output gate
);
  localparam int DIAG_MIN = ldd_pkg::DIAG_CYC - 1;
  logic       sck_q_r;
  logic       ld_q_r;
  logic       gate_q_r;
  logic       diag_r;
  logic [2:0] ev_r;
  logic [7:0] lo_cnt_r;
  logic [7:0] hi_cnt_r;
  logic [7:0] glow_cnt_r;
  logic       sck_rise;
  logic       ld_fall;

  assign sck_rise = serial_clk & ~sck_q_r;
  assign ld_fall  = ld_q_r & ~load_strobe;

  ////////////////////////////////////////////////////////////////////////////////
  // edge history and pulse counters
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_q_r    <= 1'b0;
      ld_q_r     <= 1'b0;
      gate_q_r   <= 1'b1;
      diag_r     <= 1'b0;
      ev_r       <= 3'h0;
      lo_cnt_r   <= 8'h00;
      hi_cnt_r   <= 8'h00;
      glow_cnt_r <= 8'h00;
    end
    else
    begin
      sck_q_r    <= serial_clk;
      ld_q_r     <= load_strobe;
      gate_q_r   <= drive_gate_n;
      ev_r       <= {ev_r[1:0], sck_rise | ld_fall};
      lo_cnt_r   <= load_strobe ? 8'h00 : lo_cnt_r + {7'h00, sck_rise};
      hi_cnt_r   <= load_strobe ? hi_cnt_r + {7'h00, sck_rise} : 8'h00;
      glow_cnt_r <= drive_gate_n ? 8'h00 : glow_cnt_r + {7'h00, glow_cnt_r != 8'hff};
      if (ld_fall && hi_cnt_r == 8'h03)
        diag_r <= 1'b1;
      else if (drive_gate_n && !gate_q_r)
        diag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_diag_end;
    $rose(drive_gate_n) && diag_r;
  endsequence

  a_out_on_event: assert property ($changed(chain_serial_out) |-> ev_r != 3'h0)
    else $error("serial out changed without clock or strobe edge");
  a_sck_spacing: assert property ($changed(serial_clk) |=> $stable(serial_clk) [*2])
    else $error("serial clock edges too close");
  a_sin_hold: assert property ($rose(serial_clk) |->
    $stable(chain_serial_in) ##1 $stable(chain_serial_in))
    else $error("serial data moved at clock rise");
  a_frame_bits: assert property ($rose(load_strobe) |->
    (lo_cnt_r == 0 || lo_cnt_r == NB))
    else $error("frame length not a whole device");
  a_pulse_max: assert property (load_strobe |-> hi_cnt_r <= 8'h03)
    else $error("more than three select pulses");
  a_ld_gate_low: assert property ($fell(load_strobe) |-> ##[0:1] !drive_gate_n)
    else $error("gate not low after strobe fall");
  a_diag_gate_time: assert property (s_diag_end |-> glow_cnt_r >= DIAG_MIN)
    else $error("test gate low too short");
  a_select_after: assert property (s_diag_end |-> ##[1:16] $rose(load_strobe))
    else $error("no report select after test");
endmodule

//--- sim/ldd_tb.sv
`timescale 1ns/1ps
module ldd_tb;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        temp_ok = 1'b1;
  logic [1:0]  cmd_op = 2'h0;
  logic [1:0]  cmd_sel = 2'h0;
  logic [15:0] tx_data = 16'h0000;
  logic [15:0] led_open_n = 16'hffff;
  logic [15:0] led_short_n = 16'hffff;
  logic [15:0] rx_data, sinks, disp, d, sat;
  logic        cmd_ready, done, red;
  int          err_total = 0;
  int          compares = 0;
  int          seed = 32'h2fa3;
  int          rcnt, k;
  int          ton[16];

  always #50 clk_sys = ~clk_sys;

  ldd_link_if link_if ();
  ldd_host_end #(.N_DEV(1)) i_ldd_host_end (.clk_sys, .resetn, .ce, .cmd_valid, .cmd_op,
    .cmd_sel, .tx_data, .cmd_ready, .rx_data, .done, .link(link_if));
  ldd_dev_end i_ldd_dev_end (.clk_sys, .resetn, .ce, .led_open_n, .led_short_n, .temp_ok,
    .sink_outputs(sinks), .reduced_test_current(red), .link(link_if));
  ldd_link_props #(.NB(16)) i_ldd_link_props (.clk_sys, .resetn, .serial_clk(link_if.serial_clk),
    .chain_serial_in(link_if.chain_serial_in), .chain_serial_out(link_if.chain_serial_out),
    .load_strobe(link_if.load_strobe), .drive_gate_n(link_if.drive_gate_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // report expected after a select, from the pattern shown at the gate rise
  function automatic logic [15:0] exp_rep(input logic [1:0] sel, input logic [15:0] pat);
    if (sel == ldd_pkg::SEL_OPEN)
      return led_open_n | ~pat;
    if (sel == ldd_pkg::SEL_SHORT)
      return led_short_n | ~pat;
    return {15'h7fff, temp_ok};
  endfunction

  task automatic run(input ldd_pkg::ldd_op_t op, input logic [1:0] sel, input logic [15:0] dat);
    int n;
    n = 0;
    rcnt = 0;
    sat = 16'h0000;
    while (cmd_ready !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    cmd_valid <= 1'b1;
    cmd_op <= 2'(op);
    cmd_sel <= sel;
    tx_data <= dat;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (red === 1'b1)
      begin
        rcnt++;
        sat = sinks;
      end
    end while (done !== 1'b1 && n < 3000);
    chk1("done", 1'b1, done);
    chk1("ready", 1'b1, cmd_ready);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(100 * 60000);
    err_total++;
    end_of_test();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    chk16("sinks in reset", 16'h0000, sinks);
    chk1("reduced in reset", 1'b0, red);
    chk1("serial out in reset", 1'b1, link_if.chain_serial_out);
    resetn <= 1'b1;
    run(ldd_pkg::OP_FRAME, 2'h0, 16'hffff);
    foreach (ton[i]) ton[i] = -1;
    // channel 0 is already on when done is seen, so look before waiting
    for (int c = 0; c < 24; c++)
    begin
      foreach (ton[i]) if (sinks[i] === 1'b1 && ton[i] < 0) ton[i] = c;
      @(posedge clk_sys);
    end
    foreach (ton[i]) chk1("stagger", 1'b1, ton[i] - ton[0] == i * ldd_pkg::STEP_CYC);
    disp = 16'hffff;
    for (k = 0; k < 6; k++)
    begin
      @(posedge clk_sys);
      temp_ok <= 1'($random(seed));
      led_open_n <= 16'($random(seed));
      led_short_n <= 16'($random(seed));
      @(posedge clk_sys);
      run(ldd_pkg::OP_SELECT, 2'(k % 3), 16'h0000);
      d = (k == 5) ? 16'h0000 : 16'($random(seed));
      run(ldd_pkg::OP_FRAME, 2'h0, d);
      chk16("report", exp_rep(2'(k % 3), disp), rx_data);
      disp = d;
      repeat (20) @(posedge clk_sys);
      chk16("display", disp, sinks);
    end
    disp = 16'($random(seed));
    run(ldd_pkg::OP_FRAME, 2'h0, disp);
    chk16("temperature", {15'h7fff, temp_ok}, rx_data);
    for (k = 1; k < 3; k++)
    begin
      @(posedge clk_sys);
      led_open_n <= 16'($random(seed));
      led_short_n <= 16'($random(seed));
      @(posedge clk_sys);
      run(ldd_pkg::OP_DIAG, 2'(k), 16'h0000);
      chk1("reduced span", 1'b1, (rcnt - ldd_pkg::DIAG_CYC) inside {[-1:1]});
      chk16("test pattern", ldd_pkg::ALL_ON, sat);
      chk1("reduced ended", 1'b0, red);
      repeat (20) @(posedge clk_sys);
      chk16("restored", disp, sinks);
      d = 16'($random(seed));
      run(ldd_pkg::OP_FRAME, 2'h0, d);
      chk16("test report", (k == 1) ? led_open_n : led_short_n, rx_data);
      disp = d;
    end
    end_of_test();
  end
endmodule
